// ===== inc/page_buf_if.sv
// Interface between the controller and its page buffer memory.
interface page_buf_if #(
  parameter int IDX_W = 4,
  parameter int DATA_W = 8
);
  logic we;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;
  modport ctrl (output we, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem (input we, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// ===== inc/page_write_pkg.sv
// Constants shared by the page write controller and its page buffer.
package page_write_pkg;
  // Array and page geometry.
  localparam int ADDR_W = 9;
  localparam int PAGE_BYTES = 16;
  localparam int IDX_W = 4;
  localparam int PAGE_W = ADDR_W - IDX_W;
  // Serial framing.
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam int CTRL_RW_BIT = 0;
  localparam int CTRL_A8_BIT = 1;
  // Timing.
  localparam int CLK_PERIOD_NS = 4;
  localparam int GLITCH_NS = 150;
  localparam int FILT_CNT_W = 8;
  // Commit walk runs one step past the last byte to drain the read latency.
  localparam logic [4:0] CMT_LAST = 5'h10;
  // Reset values.
  localparam logic [PAGE_BYTES-1:0] MASK_RST = 16'h0000;
  // Receive phases.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CTRL = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_COMMIT = 3'b100
  } phase_t;
endpackage

// ===== tb/i2c_host_model.sv
// Behavioural two-wire bus master that drives the serial link.
module i2c_host_model (
  // Clock and line.
  input wire logic i_clk,
  input wire logic i_sda_line,
  // Driven pins; a high data value releases the line.
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic glitch = 1'b0;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic put_bit(input logic v, output logic s);
    w(1);
    o_sda = v;
    w(4);
    o_scl = 1'b1;
    w(2);
    s = i_sda_line;
    if (glitch) begin
      o_sda = ~v;
      w(1);
      o_sda = v;
      glitch = 1'b0;
    end else begin
      w(1);
    end
    o_scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic start();
    o_sda = 1'b1;
    w(5);
    o_scl = 1'b1;
    w(3);
    o_sda = 1'b0;
    w(3);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    w(1);
    o_sda = 1'b0;
    w(4);
    o_scl = 1'b1;
    w(3);
    o_sda = 1'b1;
    w(3);
  endtask
endmodule

// ===== tb/page_write_ctrl_sva.sv
// Assertions on the page write controller ports.
module page_write_ctrl_sva (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Watched pins.
  input wire logic i_scl,
  input wire logic o_sda_oe,
  input wire logic o_mem_we,
  input wire logic [page_write_pkg::ADDR_W-1:0] o_mem_addr,
  input wire logic o_busy,
  input wire logic o_cancel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_walk;
    o_busy [*8] ##[1:20] !o_busy;
  endsequence
  property p_page;
    logic [4:0] pg;
    (o_mem_we, pg = o_mem_addr[8:4]) ##[1:17] o_mem_we |-> o_mem_addr[8:4] == pg;
  endproperty
  property p_up;
    logic [3:0] ix;
    (o_mem_we, ix = o_mem_addr[3:0]) ##[1:17] o_mem_we |-> o_mem_addr[3:0] > ix;
  endproperty
  a_we_in_walk: assert property (o_mem_we |-> $past(o_busy, 2) && !o_sda_oe)
    else $error("write outside commit");
  a_walk_ends: assert property ($rose(o_busy) |-> s_walk) else $error("commit too long");
  a_page_fixed: assert property (p_page) else $error("page changed");
  a_slots_up: assert property (p_up) else $error("slot order");
  a_ack_stands: assert property ($rose(o_sda_oe) |-> o_sda_oe [*6]) else $error("ack short");
  a_ack_late: assert property ($rose(o_sda_oe) |-> !$past(i_scl, 4) && !$past(i_scl, 5))
    else $error("ack before filtered fall");
  a_cancel_quiet: assert property (o_cancel |-> ##1 (!o_busy && !o_mem_we) [*8])
    else $error("write after cancel");
  a_cancel_no_ack: assert property (o_cancel |-> !o_sda_oe) else $error("ack on cancel");
endmodule
bind page_write_ctrl page_write_ctrl_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_scl(i_scl), .o_sda_oe(o_sda_oe), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
  .o_busy(o_busy), .o_cancel(o_cancel));

// ===== tb/tb.sv
// Self-checking bench for the page write controller.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_m;
  logic sda_oe;
  logic sda_o;
  logic sda_line;
  logic we;
  logic busy;
  logic cancel;
  logic [page_write_pkg::ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic [16:0] got[$];
  logic [16:0] exp[$];
  int error_cnt = 0;
  int total_checks = 0;
  int cancels = 0;
  always #2 clk = ~clk;
  assign sda_line = sda_m & (~sda_oe | sda_o);
  i2c_host_model m_host (.i_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda(sda_m));
  page_write_ctrl #(.GLITCH_NS(4)) u_page_write_ctrl (.i_clk_sys(clk), .i_rst(rst),
    .i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_o), .o_sda_oe(sda_oe), .o_mem_we(we),
    .o_mem_addr(addr), .o_mem_wdata(wdata), .o_busy(busy), .o_cancel(cancel));
  always @(posedge clk) begin
    if (we === 1'b1) got.push_back({addr, wdata});
    if (cancel === 1'b1) cancels++;
  end
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic settle();
    for (int n = 0; n < 30 && busy !== 1'b1; n++) @(posedge clk);
    for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task automatic cmp_writes();
    chk(got.size() == exp.size(), "write count");
    foreach (exp[i]) if (i < got.size()) chk(got[i] === exp[i], "write value");
    got.delete();
    exp.delete();
  endtask
  task automatic head(input logic [7:0] c, input logic [7:0] a);
    logic k;
    m_host.start();
    m_host.send(c, k);
    chk(k, "no ack on control");
    m_host.send(a, k);
    chk(k, "no ack on address");
  endtask
  task automatic t_wrap();
    logic k;
    head(8'hA2, 8'h50);
    for (int i = 0; i < 18; i++) begin
      m_host.send(8'h10 + 8'(i), k);
      chk(k, "no ack on data");
    end
    m_host.stop();
    settle();
    for (int i = 0; i < 16; i++) exp.push_back({9'h150 + 9'(i), 8'h10 + 8'(i < 2 ? i + 16 : i)});
    cmp_writes();
  endtask
  task automatic t_partial();
    logic k;
    head(8'hA0, 8'h3E);
    m_host.glitch = 1'b1;
    m_host.send(8'hC1, k);
    m_host.send(8'hC2, k);
    m_host.send(8'hC3, k);
    m_host.stop();
    settle();
    exp.push_back({9'h030, 8'hC3});
    exp.push_back({9'h03E, 8'hC1});
    exp.push_back({9'h03F, 8'hC2});
    cmp_writes();
  endtask
  task automatic t_cancel();
    logic k;
    head(8'hA0, 8'h20);
    for (int i = 0; i < 4; i++) m_host.put_bit(1'b0, k);
    m_host.stop();
    settle();
    chk(cancels == 1, "no cancel pulse");
    cmp_writes();
  endtask
  task automatic t_restart();
    logic k;
    head(8'hA0, 8'h70);
    m_host.send(8'hEE, k);
    head(8'hA0, 8'h20);
    m_host.send(8'h5A, k);
    m_host.stop();
    settle();
    exp.push_back({9'h020, 8'h5A});
    cmp_writes();
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    t_wrap();
    t_partial();
    t_cancel();
    t_restart();
    print_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule

// ===== verilog/page_buf_mem.sv
// Page buffer memory with registered read data.
module page_buf_mem #(
  parameter int DEPTH = 16,
  parameter int DATA_W = 8
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Buffer port.
  page_buf_if.mem pb
);
  logic [DATA_W-1:0] mem_r [DEPTH];

  initial begin
    if (DEPTH != (1 << $bits(pb.rd_idx))) begin
      $error("page_buf_mem: depth must match index width");
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (pb.we) begin
      mem_r[pb.wr_idx] <= pb.wr_data;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pb.rd_data <= '0;
    end else begin
      pb.rd_data <= mem_r[pb.rd_idx];
    end
  end
endmodule

// ===== verilog/page_write_ctrl.sv
// Write path controller of a two-wire serial memory slave.
// Behaviour
// - Start midway abandons transfer and begins a new frame; stop midway abandons it, standby.
// - Stop inside a data byte cancels write.
// - Stop after whole bytes programs those bytes.
// - Sixteen byte page, index wraps past end.
// - Write data never leaves the addressed page.
// - Pulses of 150 ns or less are ignored.
// - Address advances at eighth bit falling edge.
module page_write_ctrl #(
  parameter int GLITCH_NS = page_write_pkg::GLITCH_NS
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Serial link pins.
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Array programming port.
  output logic o_mem_we,
  output logic [page_write_pkg::ADDR_W-1:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  // Status.
  output logic o_busy,
  output logic o_cancel
);
  localparam int FILT_CYC = (GLITCH_NS + page_write_pkg::CLK_PERIOD_NS - 1)
                            / page_write_pkg::CLK_PERIOD_NS;
  localparam logic [page_write_pkg::FILT_CNT_W-1:0] FILT_LIM =
    page_write_pkg::FILT_CNT_W'(FILT_CYC);

  initial begin
    if (FILT_CYC < 1 || FILT_CYC > 254) begin
      $error("page_write_ctrl: glitch time out of range");
    end
  end

  page_buf_if #(.IDX_W(page_write_pkg::IDX_W), .DATA_W(8)) pb ();

  page_buf_mem #(.DEPTH(page_write_pkg::PAGE_BYTES), .DATA_W(8)) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .pb(pb.mem)
  );

  // Two-flop synchronisers followed by glitch filters, index 0 is clock, 1 is data.
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] flt_r;
  logic [1:0] flt_prev_r;
  logic [page_write_pkg::FILT_CNT_W-1:0] flt_cnt_r [2];

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
    end else begin
      pin_s1_r <= {i_sda, i_scl};
      pin_s2_r <= pin_s1_r;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_filt
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        flt_r[g] <= 1'b1;
        flt_cnt_r[g] <= '0;
      end else if (pin_s2_r[g] == flt_r[g]) begin
        flt_cnt_r[g] <= '0;
      end else if (flt_cnt_r[g] == FILT_LIM) begin
        flt_r[g] <= pin_s2_r[g];
        flt_cnt_r[g] <= '0;
      end else begin
        flt_cnt_r[g] <= flt_cnt_r[g] + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      flt_prev_r <= 2'h3;
    end else begin
      flt_prev_r <= flt_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = flt_r[0] & ~flt_prev_r[0];
  assign scl_fall = ~flt_r[0] & flt_prev_r[0];
  assign start_cond = flt_r[0] & flt_prev_r[0] & ~flt_r[1] & flt_prev_r[1];
  assign stop_cond = flt_r[0] & flt_prev_r[0] & flt_r[1] & ~flt_prev_r[1];

  page_write_pkg::phase_t phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic ack_r;
  logic addr_hi_r;
  logic [page_write_pkg::PAGE_W-1:0] page_r;
  logic [page_write_pkg::IDX_W-1:0] idx_r;
  logic [page_write_pkg::PAGE_BYTES-1:0] mask_r;
  logic [4:0] cmt_cnt_r;
  logic byte_done;
  logic whole_bytes;
  assign byte_done = scl_fall && bit_cnt_r == page_write_pkg::BIT_LAST;
  // The rise just before a stop takes one bit, so a count of one means none completed.
  assign whole_bytes = bit_cnt_r == 4'h0 || bit_cnt_r == 4'h1 ||
                       bit_cnt_r == page_write_pkg::BIT_ACK;

  // Phase sequencing and bit counting.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      phase_r <= page_write_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ack_r <= 1'b0;
    end else if (phase_r == page_write_pkg::ST_COMMIT) begin
      if (cmt_cnt_r == page_write_pkg::CMT_LAST) begin
        phase_r <= page_write_pkg::ST_IDLE;
      end
    end else if (start_cond) begin
      phase_r <= page_write_pkg::ST_CTRL;
      bit_cnt_r <= 4'h0;
      ack_r <= 1'b0;
    end else if (stop_cond) begin
      bit_cnt_r <= 4'h0;
      ack_r <= 1'b0;
      if (phase_r == page_write_pkg::ST_DATA && whole_bytes && mask_r != '0) begin
        phase_r <= page_write_pkg::ST_COMMIT;
      end else begin
        phase_r <= page_write_pkg::ST_IDLE;
      end
    end else if (phase_r != page_write_pkg::ST_IDLE) begin
      if (scl_rise && bit_cnt_r < page_write_pkg::BIT_LAST) begin
        shift_r <= {shift_r[6:0], flt_r[1]};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (byte_done) begin
        bit_cnt_r <= page_write_pkg::BIT_ACK;
        if (phase_r == page_write_pkg::ST_CTRL && shift_r[page_write_pkg::CTRL_RW_BIT]) begin
          phase_r <= page_write_pkg::ST_IDLE;
        end else begin
          ack_r <= 1'b1;
          if (phase_r == page_write_pkg::ST_CTRL) begin
            phase_r <= page_write_pkg::ST_ADDR;
          end else if (phase_r == page_write_pkg::ST_ADDR) begin
            phase_r <= page_write_pkg::ST_DATA;
          end
        end
      end else if (scl_fall && bit_cnt_r == page_write_pkg::BIT_ACK) begin
        bit_cnt_r <= 4'h0;
        ack_r <= 1'b0;
      end
    end
  end

  // Address capture and in-page index, which wraps inside the page.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      addr_hi_r <= 1'b0;
      page_r <= '0;
      idx_r <= '0;
    end else if (byte_done && phase_r == page_write_pkg::ST_CTRL) begin
      addr_hi_r <= shift_r[page_write_pkg::CTRL_A8_BIT];
    end else if (byte_done && phase_r == page_write_pkg::ST_ADDR) begin
      page_r <= {addr_hi_r, shift_r[7:page_write_pkg::IDX_W]};
      idx_r <= shift_r[page_write_pkg::IDX_W-1:0];
    end else if (byte_done && phase_r == page_write_pkg::ST_DATA) begin
      idx_r <= idx_r + 1'b1;
    end
  end

  // Record of the page bytes fully received in this frame.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mask_r <= page_write_pkg::MASK_RST;
    end else if (phase_r == page_write_pkg::ST_COMMIT) begin
      if (cmt_cnt_r == page_write_pkg::CMT_LAST) begin
        mask_r <= page_write_pkg::MASK_RST;
      end
    end else if (start_cond || (stop_cond && !whole_bytes)) begin
      mask_r <= page_write_pkg::MASK_RST;
    end else if (byte_done && phase_r == page_write_pkg::ST_DATA) begin
      mask_r[idx_r] <= 1'b1;
    end
  end

  assign pb.we = byte_done && phase_r == page_write_pkg::ST_DATA;
  assign pb.wr_idx = idx_r;
  assign pb.wr_data = shift_r;
  assign pb.rd_idx = cmt_cnt_r[page_write_pkg::IDX_W-1:0];

  // Commit walk over the page buffer, one array write per filled page slot, in slot order.
  logic pend_r;
  logic [page_write_pkg::IDX_W-1:0] pend_idx_r;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cmt_cnt_r <= 5'h00;
      pend_r <= 1'b0;
      pend_idx_r <= '0;
    end else if (phase_r == page_write_pkg::ST_COMMIT) begin
      cmt_cnt_r <= cmt_cnt_r + 5'h01;
      pend_r <= cmt_cnt_r < page_write_pkg::CMT_LAST &&
                mask_r[cmt_cnt_r[page_write_pkg::IDX_W-1:0]];
      pend_idx_r <= cmt_cnt_r[page_write_pkg::IDX_W-1:0];
    end else begin
      cmt_cnt_r <= 5'h00;
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_mem_we <= 1'b0;
      o_mem_addr <= '0;
      o_mem_wdata <= 8'h00;
    end else begin
      o_mem_we <= pend_r;
      o_mem_addr <= {page_r, pend_idx_r};
      o_mem_wdata <= pb.rd_data;
    end
  end

  // Cancel pulse when a stop ends a write with a partial byte.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cancel <= 1'b0;
    end else begin
      o_cancel <= stop_cond && phase_r == page_write_pkg::ST_DATA && !whole_bytes;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = ack_r;
  assign o_busy = phase_r == page_write_pkg::ST_COMMIT || pend_r || o_mem_we;
endmodule
